// *** design/dcc_pkg.sv ***
// Package for the device capability and device control register bank.
// Holds the register offsets, field positions, reset values and carrier
// structs. Assumes a 32-bit classic Wishbone slave with byte addresses.
package dcc_pkg;

   // Bus geometry.
   localparam int unsigned ADDR_W = 10;  // Byte address width of the slave.
   localparam int unsigned DATA_W = 32;  // Data width of the slave.

   // Register byte offsets.
   localparam logic [9:0] OFF_DEV_CAP   = 10'h0E4; // Device capabilities word.
   localparam logic [9:0] OFF_DEV_CTL   = 10'h0E8; // Device control and status word.
   localparam logic [9:0] OFF_IRQ_STAT  = 10'h200; // Sticky event status.
   localparam logic [9:0] OFF_IRQ_MASK  = 10'h204; // Event mask.

   // Capability field positions.
   localparam int unsigned CAP_MPS_LSB   = 0;   // Supported payload, bits 2:0.
   localparam int unsigned CAP_PHF_LSB   = 3;   // Phantom functions, bits 4:3.
   localparam int unsigned CAP_L0S_LSB   = 6;   // L0s acceptable latency, bits 8:6.
   localparam int unsigned CAP_L1_LSB    = 9;   // L1 acceptable latency, bits 11:9.
   localparam int unsigned CAP_RBER_BIT  = 15;  // Role-based error reporting.
   localparam int unsigned CAP_SPLV_LSB  = 18;  // Slot power limit value, bits 25:18.
   localparam int unsigned CAP_SPLS_LSB  = 26;  // Slot power limit scale, bits 27:26.

   // Control and status field positions.
   localparam int unsigned CTL_ERR_LSB   = 0;   // Four reporting enables, bits 3:0.
   localparam int unsigned CTL_MPS_LSB   = 5;   // Programmed payload, bits 7:5.
   localparam int unsigned CTL_AUX_BIT   = 10;  // Auxiliary power enable.
   localparam int unsigned STA_ERR_LSB   = 16;  // Four detected flags, bits 19:16.

   // Fixed and reset values.
   localparam logic [2:0] MPS_SUPPORTED  = 3'h0; // Encoding of 128 bytes.
   localparam logic [2:0] L0S_LATENCY    = 3'h0; // L0s to L0 acceptable latency.
   localparam logic [2:0] L1_LATENCY     = 3'h0; // L1 to L0 acceptable latency.
   localparam logic       RBER_RESET     = 1'h1; // Role-based reporting after reset.
   localparam logic [7:0] SPLV_RESET     = 8'h00; // Slot power value after reset.
   localparam logic [1:0] SPLS_RESET     = 2'h0;  // Slot power scale after reset.
   localparam logic [3:0] ERR_EN_RESET   = 4'h0;  // Reporting enables after reset.
   localparam logic [4:0] IRQ_MASK_RESET = 5'h00; // Mask after reset.
   localparam int unsigned N_ERR         = 4;     // Number of error classes.
   localparam int unsigned N_EVT         = 5;     // Interrupt events: errors and slot power.

   // Captured slot power limit from a received message.
   typedef struct packed {
      logic [1:0] scale;  // Limit scale.
      logic [7:0] value;  // Limit value.
   } dcc_slot_pwr_s;

   // Control bits that steer the rest of the endpoint.
   typedef struct packed {
      logic       aux_pm_en;  // Auxiliary power draw permitted.
      logic [2:0] max_pl;     // Programmed payload size.
      logic [3:0] err_en;     // UR, fatal, non-fatal, correctable enables.
   } dcc_ctl_s;

endpackage

// *** design/dcc_regs.sv ***
// Device capability and device control register bank of a PCI Express
// endpoint, with the detected-error flags and an event interrupt.
// Assumes a classic Wishbone master on the same clock, event pulses from
// the link core on the same clock, and a separate power-on reset.
//
// Implementation choice: the Wishbone slave port.

`timescale 1ns/1ps
`default_nettype none

module dcc_regs (
   // Clock and resets.
   input  wire logic                  CLK_SYS,
   input  wire logic                  ARST_N,
   input  wire logic                  PORST_N,
   // Wishbone slave.
   input  wire logic                  WB_CYC_I,
   input  wire logic                  WB_STB_I,
   input  wire logic                  WB_WE_I,
   input  wire logic [9:0]            WB_ADR_I,
   input  wire logic [3:0]            WB_SEL_I,
   input  wire logic [31:0]           WB_DAT_I,
   output logic      [31:0]           WB_DAT_O,
   output logic                       WB_ACK_O,
   // Events from the link core.
   input  wire logic [3:0]            ERR_EVT,
   input  wire logic                  SLOT_PWR_VALID,
   input  wire dcc_pkg::dcc_slot_pwr_s SLOT_PWR_MSG,
   // Autoload of the role-based reporting bit.
   input  wire logic                  RBER_LOAD_VALID,
   input  wire logic                  RBER_LOAD_VALUE,
   // Control outputs to the endpoint.
   output dcc_pkg::dcc_ctl_s          CTL_OUT,
   // Interrupt.
   output logic                       IRQ
);

   // Merges write data into an old value under the byte enables.
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Bus handshake state.
   logic        ack_q;        // Acknowledge, high for one cycle per request.
   logic [31:0] rdat_q;       // Registered read data.
   logic        req;          // New request not yet acknowledged.
   logic        wr_ctl;       // Write to the control and status word.
   logic        wr_istat;     // Write to the interrupt status.
   logic        wr_imask;     // Write to the interrupt mask.
   logic [31:0] wr_ctl_m;     // Control word after byte-enable merge.

   // Stored state.
   logic                   rber_q;     // Role-based error reporting capability.
   dcc_pkg::dcc_slot_pwr_s spl_q;      // Captured slot power limit.
   logic [3:0]             err_en_q;   // Reporting enables.
   logic [2:0]             max_pl_q;   // Programmed payload size.
   logic                   aux_en_q;   // Sticky auxiliary power enable.
   logic [3:0]             err_det_q;  // Detected-error flags.
   logic [4:0]             istat_q;    // Sticky interrupt events.
   logic [4:0]             imask_q;    // Interrupt mask.
   logic                   irq_q;      // Registered interrupt line.
   logic [2:0]             pl_wr;      // Payload field of a write.
   logic [4:0]             evt;        // Interrupt event pulses.

   // Assembled read words.
   logic [31:0] cap_word;     // Device capabilities word.
   logic [31:0] ctl_word;     // Device control and status word.

   // A request is new while the strobe is up and not yet answered.
   assign req      = WB_CYC_I & WB_STB_I & ~ack_q;
   assign wr_ctl   = req & WB_WE_I & (WB_ADR_I == dcc_pkg::OFF_DEV_CTL);
   assign wr_istat = req & WB_WE_I & (WB_ADR_I == dcc_pkg::OFF_IRQ_STAT);
   assign wr_imask = req & WB_WE_I & (WB_ADR_I == dcc_pkg::OFF_IRQ_MASK);
   assign wr_ctl_m = lane_merge(ctl_word, WB_DAT_I, WB_SEL_I);
   assign evt      = {SLOT_PWR_VALID, ERR_EVT};

   // The capability word is fixed except for the loadable fields.
   always_comb begin
      cap_word = 32'h0000_0000;
      cap_word[dcc_pkg::CAP_MPS_LSB +: 3] = dcc_pkg::MPS_SUPPORTED;
      cap_word[dcc_pkg::CAP_PHF_LSB +: 2] = 2'h0;
      cap_word[dcc_pkg::CAP_L0S_LSB +: 3] = dcc_pkg::L0S_LATENCY;
      cap_word[dcc_pkg::CAP_L1_LSB +: 3]  = dcc_pkg::L1_LATENCY;
      cap_word[dcc_pkg::CAP_RBER_BIT]     = rber_q;
      cap_word[dcc_pkg::CAP_SPLV_LSB +: 8] = spl_q.value;
      cap_word[dcc_pkg::CAP_SPLS_LSB +: 2] = spl_q.scale;
   end

   // The control word shows only the implemented bits; the rest read zero.
   always_comb begin
      ctl_word = 32'h0000_0000;
      ctl_word[dcc_pkg::CTL_ERR_LSB +: 4] = err_en_q;
      ctl_word[dcc_pkg::CTL_MPS_LSB +: 3] = max_pl_q;
      ctl_word[dcc_pkg::CTL_AUX_BIT]      = aux_en_q;
      ctl_word[dcc_pkg::STA_ERR_LSB +: 4] = err_det_q;
   end

   // Acknowledge every request one cycle after it appears, for one cycle.
   // The answer masks the request for one cycle, so a strobe still high in the
   // acknowledge cycle is not taken twice; a strobe held longer is a new request.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_q <= 1'h0;
      end else begin
         ack_q <= req;
      end
   end

   // Read data is captured with the acknowledge; unmapped addresses read zero.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         rdat_q <= 32'h0000_0000;
      end else if (req && !WB_WE_I) begin
         case (WB_ADR_I)
            dcc_pkg::OFF_DEV_CAP:  rdat_q <= cap_word;
            dcc_pkg::OFF_DEV_CTL:  rdat_q <= ctl_word;
            dcc_pkg::OFF_IRQ_STAT: rdat_q <= {27'h0, istat_q};
            dcc_pkg::OFF_IRQ_MASK: rdat_q <= {27'h0, imask_q};
            default:               rdat_q <= 32'h0000_0000;
         endcase
      end
   end

   // The role-based bit resets to one and follows the autoload sequence.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         rber_q <= dcc_pkg::RBER_RESET;
      end else if (RBER_LOAD_VALID) begin
         rber_q <= RBER_LOAD_VALUE;
      end
   end

   // The slot power limit is captured from each received message.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         spl_q.value <= dcc_pkg::SPLV_RESET;
         spl_q.scale <= dcc_pkg::SPLS_RESET;
      end else if (SLOT_PWR_VALID) begin
         spl_q.value <= SLOT_PWR_MSG.value;
         spl_q.scale <= SLOT_PWR_MSG.scale;
      end
   end

   // Reporting enables are plain read-write bits.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         err_en_q <= dcc_pkg::ERR_EN_RESET;
      end else if (wr_ctl) begin
         err_en_q <= wr_ctl_m[dcc_pkg::CTL_ERR_LSB +: 4];
      end
   end

   // A payload above the supported size is clamped to the supported size.
   assign pl_wr = wr_ctl_m[dcc_pkg::CTL_MPS_LSB +: 3];

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         max_pl_q <= 3'h0;
      end else if (wr_ctl) begin
         if (pl_wr > dcc_pkg::MPS_SUPPORTED) begin
            max_pl_q <= dcc_pkg::MPS_SUPPORTED;
         end else begin
            max_pl_q <= pl_wr;
         end
      end
   end

   // The auxiliary enable is sticky: of the two resets only the power-on reset clears it.
   always_ff @(posedge CLK_SYS or negedge PORST_N) begin
      if (!PORST_N) begin
         aux_en_q <= 1'h0;
      end else if (wr_ctl) begin
         aux_en_q <= wr_ctl_m[dcc_pkg::CTL_AUX_BIT];
      end
   end

   // Detected-error flags: each error sets its flag, a written one clears it,
   // and an error in the clearing cycle keeps the flag set.
   genvar gi;
   generate
      for (gi = 0; gi < dcc_pkg::N_ERR; gi++) begin : g_det
         always_ff @(posedge CLK_SYS or negedge ARST_N) begin
            if (!ARST_N) begin
               err_det_q[gi] <= 1'h0;
            end else if (ERR_EVT[gi]) begin
               err_det_q[gi] <= 1'h1;
            end else if (wr_ctl && WB_SEL_I[2] && WB_DAT_I[dcc_pkg::STA_ERR_LSB + gi]) begin
               err_det_q[gi] <= 1'h0;
            end
         end
      end
   endgenerate

   // Interrupt events are sticky and cleared by writing ones; a new event wins.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         istat_q <= 5'h00;
      end else if (wr_istat && WB_SEL_I[0]) begin
         istat_q <= (istat_q & ~WB_DAT_I[4:0]) | evt;
      end else begin
         istat_q <= istat_q | evt;
      end
   end

   // The mask is a plain read-write register.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         imask_q <= dcc_pkg::IRQ_MASK_RESET;
      end else if (wr_imask && WB_SEL_I[0]) begin
         imask_q <= WB_DAT_I[4:0];
      end
   end

   // The interrupt line is high while any unmasked event is pending.
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_q <= 1'h0;
      end else begin
         irq_q <= |(istat_q & imask_q);
      end
   end

   // Outputs straight from flip-flops.
   assign WB_ACK_O          = ack_q;
   assign WB_DAT_O          = rdat_q;
   assign CTL_OUT           = '{aux_pm_en: aux_en_q, max_pl: max_pl_q, err_en: err_en_q};
   assign IRQ               = irq_q;

   // Checks that guard the register behaviour.

   // The fixed capability fields never move.
   cap_fixed_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      cap_word[4:0] == 5'h00 && cap_word[11:6] == 6'h00)
      else $error("capability payload, phantom or latency field not zero");

   // Latency fields read zero when a capability read is answered.
   lat_read_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (req && !WB_WE_I && WB_ADR_I == dcc_pkg::OFF_DEV_CAP)
      |=> ack_q && WB_DAT_O[11:6] == 6'h00 && WB_DAT_O[31:28] == 4'h0)
      else $error("capability read returned nonzero latency or reserved bits");

   // An autoload changes the role-based bit on the next edge.
   rber_load_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      RBER_LOAD_VALID |=> rber_q == $past(RBER_LOAD_VALUE))
      else $error("role-based bit did not follow autoload");

   // A slot power message is visible in the capability word next cycle.
   slot_pwr_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      SLOT_PWR_VALID |=> cap_word[25:18] == $past(SLOT_PWR_MSG.value)
                         && cap_word[27:26] == $past(SLOT_PWR_MSG.scale))
      else $error("slot power limit not captured");

   // Control reads show zero in every unimplemented and reserved bit.
   ctl_zero_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (req && !WB_WE_I && WB_ADR_I == dcc_pkg::OFF_DEV_CTL)
      |=> WB_DAT_O[15:11] == 5'h00 && WB_DAT_O[9:8] == 2'h0 && WB_DAT_O[4] == 1'h0
          && WB_DAT_O[31:20] == 12'h000)
      else $error("control read returned nonzero unimplemented bits");

   // A control write with lane zero lands the four enables.
   err_en_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (wr_ctl && WB_SEL_I[0]) |=> CTL_OUT.err_en == $past(WB_DAT_I[3:0]))
      else $error("reporting enables did not take written value");

   // The programmed payload can never exceed the supported size.
   pl_clamp_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      wr_ctl |=> CTL_OUT.max_pl <= dcc_pkg::MPS_SUPPORTED)
      else $error("programmed payload above supported size");

   // The auxiliary enable changes only on a control write.
   aux_hold_a: assert property (
      @(posedge CLK_SYS) disable iff (!PORST_N)
      !wr_ctl |=> $stable(aux_en_q))
      else $error("auxiliary enable changed without a write");

   // A correctable error sets its flag whatever the enables say, even while cleared.
   err_flag_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      ERR_EVT[0] |=> err_det_q[0] ##1 (err_det_q[0] || $past(wr_ctl)))
      else $error("correctable flag not set by its error");

   // Each request is answered for exactly one cycle.
   ack_pulse_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      ack_q |=> !ack_q)
      else $error("acknowledge held longer than one cycle");

   // The interrupt follows a pending unmasked event by one cycle.
   irq_level_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      |(istat_q & imask_q) |=> IRQ)
      else $error("interrupt not raised for an unmasked event");

   // A bus write to the capability word leaves every field as it was.
   cap_write_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (req && WB_WE_I && WB_ADR_I == dcc_pkg::OFF_DEV_CAP
       && !SLOT_PWR_VALID && !RBER_LOAD_VALID)
      |=> $stable(cap_word))
      else $error("capability word changed on a bus write");

   // Capability reads show zero in the reserved bits 17:16, 14:12 and 5.
   cap_rsvd_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (req && !WB_WE_I && WB_ADR_I == dcc_pkg::OFF_DEV_CAP)
      |=> WB_DAT_O[17:16] == 2'h0 && WB_DAT_O[14:12] == 3'h0 && WB_DAT_O[5] == 1'h0)
      else $error("capability read returned nonzero reserved bits");

   // Every error pulse leaves its detected flag set, a clear in that cycle too.
   err_set_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (|ERR_EVT) |=> (err_det_q & $past(ERR_EVT)) == $past(ERR_EVT))
      else $error("detected flag missing after its error");

   // A control write with lane one lands the auxiliary enable.
   aux_write_a: assert property (
      @(posedge CLK_SYS) disable iff (!PORST_N)
      (wr_ctl && WB_SEL_I[1]) |=> CTL_OUT.aux_pm_en == $past(WB_DAT_I[10]))
      else $error("auxiliary enable did not take written value");

   // Every event is kept in the interrupt status, even against a clear.
   evt_keep_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (|evt) |=> (istat_q & $past(evt)) == $past(evt))
      else $error("interrupt event lost");

   // Every new request is answered in the next cycle.
   ack_next_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      req |=> ack_q)
      else $error("request not acknowledged in the next cycle");

   // The interrupt stays low while no unmasked event is pending.
   irq_quiet_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      !(|(istat_q & imask_q)) |=> !IRQ)
      else $error("interrupt raised with no unmasked event");

   // Reads of unmapped addresses return zero.
   unmapped_read_a: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (req && !WB_WE_I
       && WB_ADR_I != dcc_pkg::OFF_DEV_CAP && WB_ADR_I != dcc_pkg::OFF_DEV_CTL
       && WB_ADR_I != dcc_pkg::OFF_IRQ_STAT && WB_ADR_I != dcc_pkg::OFF_IRQ_MASK)
      |=> WB_DAT_O == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");

endmodule

`default_nettype wire

// *** tb/dcc_host_model.sv ***
// Host model: a classic Wishbone master that stands in for the root complex.
// Assumes a slave on the same clock that answers every request with ack.
`timescale 1ns/1ps
`default_nettype none

module dcc_host_model (
   // Clock.
   input  wire logic        clk,
   // Wishbone master side.
   output var  logic        cyc,
   output var  logic        stb,
   output var  logic        we,
   output var  logic [9:0]  adr,
   output var  logic [3:0]  sel,
   output var  logic [31:0] dat_w,
   input  wire logic [31:0] dat_r,
   input  wire logic        ack
);
   // The bus starts idle.
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 10'h000;
      sel = 4'h0;
      dat_w = 32'h0;
   end

   // One classic cycle; the request is held until ack is sampled high, for at most 16 cycles.
   // Released lines carry the inverse of their last value, never stale data.
   task automatic xfer(input logic w, input logic [9:0] a, input logic [3:0] s,
                       input logic [31:0] d, output logic [31:0] q, output logic ok);
      ok = 1'b0;
      q = 32'h0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      dat_w <= d;
      for (int n = 0; n < 16 && !ok; n++) begin
         @(posedge clk);
         if (ack === 1'b1) begin
            ok = 1'b1;
            q = dat_r;
         end
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= ~w;
      adr <= ~a;
      sel <= ~s;
      dat_w <= ~d;
   endtask
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the capability and control register bank.
// Assumes the host model in its own file and a 50 MHz system clock.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic                   clk_sys, arst_n, porst_n;  // Clock and resets.
   logic                   cyc, stb, we, ack, irq;    // Bus and interrupt.
   logic                   slot_v, rber_v, rber_d;    // Event strobes.
   logic [9:0]             adr;                       // Byte address.
   logic [3:0]             sel, err_evt;              // Lanes and error pulses.
   logic [31:0]            dat_w, dat_r;              // Bus data.
   dcc_pkg::dcc_slot_pwr_s slot_msg;                  // Slot power message.
   dcc_pkg::dcc_ctl_s      ctl;                       // Control outputs.
   int                     miscompares, n_checks;     // Result counters.

   dcc_regs dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .PORST_N(porst_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack), .ERR_EVT(err_evt),
      .SLOT_PWR_VALID(slot_v), .SLOT_PWR_MSG(slot_msg), .RBER_LOAD_VALID(rber_v),
      .RBER_LOAD_VALUE(rber_d), .CTL_OUT(ctl), .IRQ(irq));
   dcc_host_model host (.clk(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
      .sel(sel), .dat_w(dat_w), .dat_r(dat_r), .ack(ack));

   // Free-running 50 MHz clock; all inputs start defined and in reset.
   initial begin
      clk_sys = 1'b0;
      {arst_n, porst_n, slot_v, rber_v, rber_d, err_evt} = 9'h000;
      slot_msg = 10'h000;
   end
   always #10 clk_sys = ~clk_sys;

   // Counts a comparison and reports a mismatch at once.
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Bus write; a missing ack ends the run as a failure.
   task wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      logic [31:0] q;
      logic        ok;
      host.xfer(1'b1, a, s, d, q, ok);
      if (!ok) begin
         miscompares++;
         give_verdict();
      end
   endtask

   // Bus read compared with the expected word.
   task rd(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] q;
      logic        ok;
      host.xfer(1'b0, a, 4'hF, 32'h0, q, ok);
      if (!ok) begin
         miscompares++;
         give_verdict();
      end
      check($sformatf("word %h", a), q, e);
   endtask

   // One-cycle event pulses from the link core side.
   task pulse(input logic [3:0] e, input logic s, input logic r, input logic [9:0] m);
      @(posedge clk_sys);
      err_evt <= e;
      slot_v <= s;
      rber_v <= r;
      slot_msg <= m;
      @(posedge clk_sys);
      {err_evt, slot_v, rber_v} <= 6'h00;
   endtask

   // Waits a bounded time for the interrupt level to reach a value.
   task irq_is(input logic e);
      logic hit;
      hit = 1'b0;
      for (int n = 0; n < 8 && !hit; n++) begin
         @(posedge clk_sys);
         hit = (irq === e);
      end
      check("irq", {31'h0, irq}, {31'h0, e});
      if (!hit) give_verdict();
   endtask

   // Resets for ten cycles; the power-on reset only when asked.
   task do_reset(input logic por);
      @(posedge clk_sys);
      arst_n <= 1'b0;
      if (por) porst_n <= 1'b0;
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      porst_n <= 1'b1;
   endtask

   // Reset values, then writes that must not reach read-only fields.
   task t_fixed;
      rd(10'h0E4, 32'h0000_8000);
      rd(10'h0E8, 32'h0);
      check("ctl", {24'h0, ctl}, 32'h0);
      wr(10'h0E4, 32'hFFFF_FFFF);
      rd(10'h0E4, 32'h0000_8000);
      wr(10'h100, 32'hFFFF_FFFF);
      rd(10'h100, 32'h0);
   endtask

   // Control bits: each enable alone, the payload clamp, fixed zeros.
   task t_control;
      wr(10'h0E8, 32'hFFFF_FFFF, 4'h3);
      rd(10'h0E8, 32'h0000_040F);
      check("ctl", {24'h0, ctl}, 32'h8F);
      for (int i = 0; i < 4; i++) begin
         wr(10'h0E8, 32'h1 << i, 4'h3);
         rd(10'h0E8, 32'h1 << i);
      end
      wr(10'h0E8, 32'h20, 4'h3);
      rd(10'h0E8, 32'h0);
   endtask

   // Errors are flagged with reporting disabled; interrupt mask and clear.
   task t_errors;
      pulse(4'hF, 1'b0, 1'b0, 10'h000);
      rd(10'h0E8, 32'h000F_0000);
      rd(10'h200, 32'h0000_000F);
      irq_is(1'b0);
      wr(10'h204, 32'h1);
      irq_is(1'b1);
      wr(10'h200, 32'h1F, 4'h1);
      irq_is(1'b0);
      rd(10'h200, 32'h0);
      wr(10'h0E8, 32'h000F_0000, 4'h4);
      rd(10'h0E8, 32'h0);
      wr(10'h0E8, 32'h0000_000F, 4'h1);
      pulse(4'h5, 1'h0, 1'h0, 10'h000);
      rd(10'h0E8, 32'h0005_000F);
      irq_is(1'h1);
      wr(10'h200, 32'h1F, 4'h1);
      irq_is(1'h0);
      wr(10'h0E8, 32'h000F_0000, 4'h5);
      rd(10'h0E8, 32'h0);
   endtask

   // Slot power capture, its event bit and the autoload override.
   task t_slot;
      pulse(4'h0, 1'h1, 1'h0, {2'h3, 8'hA5});
      rd(10'h0E4, 32'h0E94_8000);
      wr(10'h204, 32'h10);
      irq_is(1'h1);
      wr(10'h200, 32'h10, 4'h1);
      irq_is(1'h0);
      rber_d <= 1'h0;
      pulse(4'h0, 1'h0, 1'h1, 10'h000);
      rd(10'h0E4, 32'h0E94_0000);
   endtask

   // Auxiliary enable survives a plain reset, not a power-on reset.
   task t_sticky;
      wr(10'h0E8, 32'h400, 4'h3);
      do_reset(1'h0);
      rd(10'h0E8, 32'h400);
      check("aux", {31'h0, ctl.aux_pm_en}, 32'h1);
      rd(10'h0E4, 32'h0000_8000);
      do_reset(1'h1);
      rd(10'h0E8, 32'h0);
   endtask

   // Main sequence.
   initial begin
      miscompares = 0;
      n_checks = 0;
      do_reset(1'b1);
      t_fixed();
      t_control();
      t_errors();
      t_slot();
      t_sticky();
      give_verdict();
   end
endmodule

`default_nettype wire
